// ### dv/dpm_dma_model.sv
// Purpose: Behavioural DMA channel side that feeds transfer events to the monitor.
// Assumes: One transfer at a time, every line changes just after a rising edge.
// Notes:   Request stays high through the wait, and start is a one-cycle pulse.
`default_nettype none
module dpm_dma_model (
    input  wire logic        clk_i,
    output var  logic [11:0] ch_data_cycle_o,
    output var  logic [11:0] ch_stall_cycle_o,
    output var  logic [11:0] ch_request_o,
    output var  logic [11:0] ch_start_o,
    output var  logic [11:0] ch_is_write_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // All channels are quiet until a transfer is asked for.
    initial begin
        ch_data_cycle_o = 12'h000;
        ch_stall_cycle_o = 12'h000;
        ch_request_o = 12'h000;
        ch_start_o = 12'h000;
        ch_is_write_o = 12'h000;
    end
    // Wait cycles, then initiation, then data and stall cycles, all on the fast bus clock.
    task automatic xfer(input int ch, input logic wr, input int w, input int nd, input int ns);
        @(posedge clk_i);
        ch_is_write_o[ch] <= wr;
        ch_request_o[ch] <= 1'b1;
        repeat (w) @(posedge clk_i);
        ch_start_o[ch] <= 1'b1;
        @(posedge clk_i);
        ch_request_o[ch] <= 1'b0;
        ch_start_o[ch] <= 1'b0;
        ch_data_cycle_o[ch] <= 1'b1;
        repeat (nd) @(posedge clk_i);
        ch_data_cycle_o[ch] <= 1'b0;
        ch_stall_cycle_o[ch] <= 1'b1;
        repeat (ns) @(posedge clk_i);
        ch_stall_cycle_o[ch] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### dv/dpm_top_monitor.sv
// Purpose: Port-level checks of the performance monitor register block.
// Assumes: One-cycle access phase with pready held high.
// Notes:   Attached to every dpm_top by the bind at the foot.
`default_nettype none
`include "dpm_defines.svh"
module dpm_top_monitor (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [11:0] ch_data_cycle_i,
    input wire logic [11:0] ch_stall_cycle_i,
    input wire logic [11:0] ch_start_i
);
    logic acc;
    logic rd;
    logic mapped;
    // Decode kept here so each property stays short.
    assign acc = psel_i && penable_i;
    assign rd = acc && !pwrite_i;
    assign mapped = paddr_i inside {12'h800, 12'h810, 12'h814, 12'h818, 12'h81c, 12'h820, 12'h824};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_ctl_wr; acc && pwrite_i && paddr_i == `DPM_OFF_CONTROL; endsequence
    sequence s_quiet; ch_data_cycle_i == 12'h000 && ch_stall_cycle_i == 12'h000 && ch_start_i == 12'h000; endsequence
    sequence s_gap; !psel_i ##1 (psel_i && !penable_i); endsequence
    a_ready_high: assert property (pready_o)
        else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr_o && prdata_o == 32'h00000000)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && mapped |-> !pslverr_o)
        else $error("error on mapped register");
    a_rdata_idle: assert property (!rd |-> prdata_o == 32'h00000000)
        else $error("read data outside a read");
    a_lat_upper: assert property (rd && paddr_i inside {12'h818, 12'h824} |-> prdata_o[31:16] == 16'h0000)
        else $error("latency upper half not zero");
    a_clear_bits: assert property (rd && paddr_i == `DPM_OFF_CONTROL |-> prdata_o[9:8] == 2'b00)
        else $error("clear bit reads one");
    // Monitor 0 must read zero right after its clear when the channels stay quiet.
    a_clear_zero: assert property (s_ctl_wr ##0 pwdata_i[8] ##1 s_quiet [*2] ##1 (rd && paddr_i inside
        {12'h810, 12'h814, 12'h818}) |-> prdata_o == 32'h00000000)
        else $error("monitor 0 not cleared");
    a_ctl_back: assert property (s_ctl_wr ##1 s_gap ##1 (rd && paddr_i == `DPM_OFF_CONTROL)
        |-> prdata_o == ($past(pwdata_i, 3) & `DPM_CONTROL_MASK & 32'hfffffcff))
        else $error("control read back differs");
endmodule
bind dpm_top dpm_top_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ch_data_cycle_i(ch_data_cycle_i), .ch_stall_cycle_i(ch_stall_cycle_i),
    .ch_start_i(ch_start_i));
`default_nettype wire

// ### dv/dpm_top_test.sv
// Purpose: Self-checking bench of the DMA performance monitor block.
// Assumes: Channel traffic comes from dpm_dma_model, registers are reached over APB.
// Notes:   Expected counts are kept in a small reference updated per transfer.
`default_nettype none
`include "dpm_defines.svh"
module dpm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [11:0] ch_data_cycle_i;
    logic [11:0] ch_stall_cycle_i;
    logic [11:0] ch_request_i;
    logic [11:0] ch_start_i;
    logic [11:0] ch_is_write_i;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [31:0] ctl = 32'h00000000;
    logic [31:0] seed = 32'hbdd86f4a;
    logic [31:0] ex [6] = '{default: 32'h00000000};
    logic [11:0] offs [6] = '{12'h810, 12'h814, 12'h818, 12'h81c, 12'h820, 12'h824};
    // Free-running fast bus clock, 10 ns period.
    always #5 clk_i = ~clk_i;
    dpm_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ch_data_cycle_i(ch_data_cycle_i), .ch_stall_cycle_i(ch_stall_cycle_i), .ch_request_i(ch_request_i),
        .ch_start_i(ch_start_i), .ch_is_write_i(ch_is_write_i));
    dpm_dma_model u_dma (.clk_i(clk_i), .ch_data_cycle_o(ch_data_cycle_i), .ch_stall_cycle_o(ch_stall_cycle_i),
        .ch_request_o(ch_request_i), .ch_start_o(ch_start_i), .ch_is_write_o(ch_is_write_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        checks_done++;
        if (q !== x || e !== xe) begin
            n_errors++;
            $display("wrong value at %0t: got %h/%h expected %h/%h", $time, q, e, x, xe);
        end
    endtask
    task automatic check_all;
        for (int i = 0; i < 6; i++) rd_chk(offs[i], ex[i], 1'b0);
    endtask
    // Clear bits reset the reference of their monitor and never read back.
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        if (a == `DPM_OFF_CONTROL) begin
            ctl = d & `DPM_CONTROL_MASK & 32'hfffffcff;
            for (int i = 0; i < 6; i++) if (d[8 + i / 3]) ex[i] = 32'h0;
        end
    endtask
    // Drive one transfer and count it where an enabled monitor watches that channel and direction.
    task automatic run(input int ch, input logic wr, input int w, input int nd, input int ns);
        int m;
        u_dma.xfer(ch, wr, w, nd, ns);
        m = wr ? 0 : 1;
        if (ctl[m] && ch == ctl[16 + 8 * m +: 6]) begin
            ex[3 * m] += nd;
            ex[3 * m + 1] += ns;
            if (w > ex[3 * m + 2]) ex[3 * m + 2] = (w > 65535) ? 65535 : w;
        end
    endtask
    // Watchdog sized above the saturation run, which dominates at about 67000 cycles.
    initial begin
        #900000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        check_all();
        rd_chk(`DPM_OFF_CONTROL, 32'h0, 1'b0);
        $display("test reset_values done");
        wr_reg(`DPM_OFF_CONTROL, 32'hc7c3fcff);
        rd_chk(`DPM_OFF_CONTROL, ctl, 1'b0);
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            run(seed[1:0] == 2'h2 ? 5 : (seed[0] ? 7 : 3), seed[2], seed[6:3], seed[8:7] + 1, seed[10:9] + 1);
            check_all();
        end
        $display("test random_traffic done");
        wr_reg(`DPM_OFF_M0_WLAT, 32'hffffffff);
        wr_reg(`DPM_OFF_M1_RDATA, 32'hffffffff);
        wr_reg(`DPM_OFF_CONTROL, ctl & 32'hfffffffe);
        run(3, 1'b1, 9, 3, 2);
        check_all();
        wr_reg(`DPM_OFF_CONTROL, ctl | 32'h1);
        rd_chk(`DPM_OFF_CONTROL, ctl, 1'b0);
        $display("test ignore_and_disable done");
        for (int m = 0; m < 2; m++) begin
            run(m ? 7 : 3, m == 0, 4, 2, 2);
            wr_reg(`DPM_OFF_CONTROL, ctl | (32'h100 << m));
            check_all();
            rd_chk(`DPM_OFF_CONTROL, ctl, 1'b0);
        end
        $display("test counter_clear done");
        rd_chk(12'h804, 32'h0, 1'b1);
        $display("test unmapped done");
        run(7, 1'b0, 66000, 1, 1);
        check_all();
        $display("test saturation done");
        finish_test();
    end
endmodule
`default_nettype wire

// ### src/dpm_defines.svh
// Purpose: Offsets, field positions, reset values and widths of the DMA performance monitor.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH
`define DPM_ADDR_W          12
`define DPM_OFF_CONTROL     12'h800
`define DPM_OFF_M0_WDATA    12'h810
`define DPM_OFF_M0_WSTALL   12'h814
`define DPM_OFF_M0_WLAT     12'h818
`define DPM_OFF_M1_RDATA    12'h81c
`define DPM_OFF_M1_RSTALL   12'h820
`define DPM_OFF_M1_RLAT     12'h824
`define DPM_BIT_EN0         0
`define DPM_BIT_EN1         1
`define DPM_BIT_OF0         4
`define DPM_BIT_OF1         5
`define DPM_BIT_RES0        8
`define DPM_BIT_RES1        9
`define DPM_CH0_LSB         16
`define DPM_CH1_LSB         24
`define DPM_CH_W            6
`define DPM_CNT_W           32
`define DPM_LAT_W           16
`define DPM_RESET_WORD      32'h00000000
`define DPM_CONTROL_MASK    32'h3f3f0033
`endif

// ### src/dpm_monitor.sv
// Purpose: One performance monitor: data, stall and maximum initiation wait counters.
// Assumes: Event inputs are on clk_i and already qualified by channel and direction.
// Notes:   Clear, freeze and overflow reset act on all three counters together.
`default_nettype none
`include "dpm_defines.svh"
module dpm_monitor (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   enable_i,
    input  wire logic                   freeze_mode_i,
    input  wire logic                   clear_i,
    input  wire logic                   data_cycle_i,
    input  wire logic                   stall_cycle_i,
    input  wire logic                   request_i,
    input  wire logic                   start_i,
    output dpm_pkg::dpm_count_type      data_count_o,
    output dpm_pkg::dpm_count_type      stall_count_o,
    output dpm_pkg::dpm_lat_type        max_wait_o
);
    dpm_pkg::dpm_count_type    next_data_count;
    dpm_pkg::dpm_count_type    next_stall_count;
    dpm_pkg::dpm_lat_type      max_wait;
    dpm_pkg::dpm_lat_type      next_max_wait;
    dpm_pkg::dpm_lat_type      wait_count;
    dpm_pkg::dpm_lat_type      next_wait_count;
    dpm_pkg::dpm_lat_state_type state;
    dpm_pkg::dpm_lat_state_type next_state;
    logic                      frozen;
    logic                      next_frozen;
    logic                      data_wrap;
    logic                      stall_wrap;
    logic                      wait_full;

    assign max_wait_o = max_wait;
    assign data_wrap  = data_cycle_i && (data_count_o == {`DPM_CNT_W{1'b1}});
    assign stall_wrap = stall_cycle_i && (stall_count_o == {`DPM_CNT_W{1'b1}});
    assign wait_full  = (wait_count == {`DPM_LAT_W{1'b1}});

    // Next values; freeze holds everything so software reads a coherent snapshot.
    always_comb begin
        next_data_count  = data_count_o;
        next_stall_count = stall_count_o;
        next_max_wait    = max_wait;
        next_wait_count  = wait_count;
        next_state       = state;
        next_frozen      = frozen;
        if (clear_i) begin
            next_data_count  = '0;
            next_stall_count = '0;
            next_max_wait    = '0;
            next_wait_count  = '0;
            next_state       = dpm_pkg::DPM_IDLE;
            next_frozen      = 1'b0;
        end else if (enable_i && !frozen) begin
            if ((data_wrap || stall_wrap) && freeze_mode_i) begin
                next_frozen = 1'b1;
            end else if (data_wrap || stall_wrap) begin
                next_data_count  = '0;
                next_stall_count = '0;
                next_max_wait    = '0;
                next_wait_count  = '0;
                next_state       = dpm_pkg::DPM_IDLE;
            end else begin
                if (data_cycle_i) begin
                    next_data_count = data_count_o + 1'b1;
                end
                if (stall_cycle_i) begin
                    next_stall_count = stall_count_o + 1'b1;
                end
                case (state)
                    dpm_pkg::DPM_IDLE: begin
                        next_wait_count = '0;
                        if (request_i && !start_i) begin
                            next_state      = dpm_pkg::DPM_WAIT;
                            next_wait_count = {{(`DPM_LAT_W-1){1'b0}}, 1'b1};
                        end
                    end
                    dpm_pkg::DPM_WAIT: begin
                        if (start_i) begin
                            next_state = dpm_pkg::DPM_IDLE;
                            if (wait_count > max_wait) begin
                                next_max_wait = wait_count;
                            end
                        end else if (!wait_full) begin
                            next_wait_count = wait_count + 1'b1;
                        end
                    end
                    default: begin
                        next_state = dpm_pkg::DPM_IDLE;
                    end
                endcase
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_count_o  <= '0;
            stall_count_o <= '0;
            max_wait      <= '0;
            wait_count    <= '0;
            state         <= dpm_pkg::DPM_IDLE;
            frozen        <= 1'b0;
        end else begin
            data_count_o  <= next_data_count;
            stall_count_o <= next_stall_count;
            max_wait      <= next_max_wait;
            wait_count    <= next_wait_count;
            state         <= next_state;
            frozen        <= next_frozen;
        end
    end
endmodule
`default_nettype wire

// ### src/dpm_pkg.sv
// Purpose: Types shared by the performance monitor files.
// Assumes: Constants come from dpm_defines.svh.
// Notes:   Holds types only.
`default_nettype none
`include "dpm_defines.svh"
package dpm_pkg;
    typedef logic [`DPM_CNT_W-1:0] dpm_count_type;
    typedef logic [`DPM_LAT_W-1:0] dpm_lat_type;
    typedef enum logic [1:0] {
        DPM_IDLE = 2'b01,
        DPM_WAIT = 2'b10
    } dpm_lat_state_type;
endpackage
`default_nettype wire

// ### src/dpm_top.sv
// Purpose: APB register block holding two DMA performance monitors.
// Assumes: DMA channel events arrive on clk_i, which is the fast DMA bus clock.
// Notes:   Monitor 0 observes writes, monitor 1 observes reads of the selected channel.
//
// Summary of operation
// - Latency register keeps the largest initiation wait since that monitor's last clear.
// - Wait is counted one per cycle of the fast DMA bus clock.
// - Wait counter saturates at all ones, never wraps.
// - Each monitor's latency cleared by writing its counter-clear bit or by an overflow reset.
// - Data register counts data cycles of the channel since the last clear.
// - Stall register counts stalled cycles of the channel since the last clear.
// - Writing one to a clear bit clears that monitor; it reads zero.
// - Overflow resets the monitor, or freezes it when freeze mode is set.
// - A monitor counts only while its enable bit is one.
//
// Register access over APB was left to the implementer.
`default_nettype none
`include "dpm_defines.svh"
module dpm_top (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [11:0]            paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    input  wire logic [11:0]            ch_data_cycle_i,
    input  wire logic [11:0]            ch_stall_cycle_i,
    input  wire logic [11:0]            ch_request_i,
    input  wire logic [11:0]            ch_start_i,
    input  wire logic [11:0]            ch_is_write_i
);
    logic [31:0]             control;
    logic [31:0]             next_control;
    logic [31:0]             next_prdata;
    logic                    next_pslverr;
    logic                    wr_en;
    logic                    rd_en;
    logic                    hit;
    logic [1:0]              clear;
    logic [5:0]              sel0;
    logic [5:0]              sel1;
    logic                    m0_data;
    logic                    m0_stall;
    logic                    m0_req;
    logic                    m0_start;
    logic                    m1_data;
    logic                    m1_stall;
    logic                    m1_req;
    logic                    m1_start;
    dpm_pkg::dpm_count_type  m0_data_count;
    dpm_pkg::dpm_count_type  m0_stall_count;
    dpm_pkg::dpm_lat_type    m0_wait;
    dpm_pkg::dpm_count_type  m1_data_count;
    dpm_pkg::dpm_count_type  m1_stall_count;
    dpm_pkg::dpm_lat_type    m1_wait;

    // Zero wait states: every access completes in its first access cycle.
    assign pready_o = 1'b1;
    assign wr_en    = psel_i && penable_i && pwrite_i;
    assign rd_en    = psel_i && !penable_i && !pwrite_i; // Setup cycle of a read; data registers at its end.
    assign sel0     = control[`DPM_CH0_LSB +: `DPM_CH_W];
    assign sel1     = control[`DPM_CH1_LSB +: `DPM_CH_W];
    // The clear bits are write strobes and are never stored, so they read zero.
    assign clear[0] = wr_en && (paddr_i == `DPM_OFF_CONTROL) && pwdata_i[`DPM_BIT_RES0];
    assign clear[1] = wr_en && (paddr_i == `DPM_OFF_CONTROL) && pwdata_i[`DPM_BIT_RES1];

    // Channel selection; an out-of-range channel number simply observes nothing.
    // Both monitors pointing at one channel is left to software.
    always_comb begin
        m0_data  = 1'b0;
        m0_stall = 1'b0;
        m0_req   = 1'b0;
        m0_start = 1'b0;
        m1_data  = 1'b0;
        m1_stall = 1'b0;
        m1_req   = 1'b0;
        m1_start = 1'b0;
        if (sel0 < 6'h0c) begin
            m0_data  = ch_data_cycle_i[sel0[3:0]] && ch_is_write_i[sel0[3:0]];
            m0_stall = ch_stall_cycle_i[sel0[3:0]] && ch_is_write_i[sel0[3:0]];
            m0_req   = ch_request_i[sel0[3:0]] && ch_is_write_i[sel0[3:0]];
            m0_start = ch_start_i[sel0[3:0]] && ch_is_write_i[sel0[3:0]];
        end
        if (sel1 < 6'h0c) begin
            m1_data  = ch_data_cycle_i[sel1[3:0]] && !ch_is_write_i[sel1[3:0]];
            m1_stall = ch_stall_cycle_i[sel1[3:0]] && !ch_is_write_i[sel1[3:0]];
            m1_req   = ch_request_i[sel1[3:0]] && !ch_is_write_i[sel1[3:0]];
            m1_start = ch_start_i[sel1[3:0]] && !ch_is_write_i[sel1[3:0]];
        end
    end

    // Control register write and read mux.
    always_comb begin
        next_control = control;
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        hit          = 1'b1;
        if (wr_en && (paddr_i == `DPM_OFF_CONTROL)) begin
            next_control = pwdata_i & `DPM_CONTROL_MASK;
        end
        case (paddr_i)
            `DPM_OFF_CONTROL:   next_prdata = control;
            `DPM_OFF_M0_WDATA:  next_prdata = m0_data_count;
            `DPM_OFF_M0_WSTALL: next_prdata = m0_stall_count;
            `DPM_OFF_M0_WLAT:   next_prdata = {16'h0000, m0_wait};
            `DPM_OFF_M1_RDATA:  next_prdata = m1_data_count;
            `DPM_OFF_M1_RSTALL: next_prdata = m1_stall_count;
            `DPM_OFF_M1_RLAT:   next_prdata = {16'h0000, m1_wait};
            default: begin
                next_prdata = 32'h00000000;
                hit         = 1'b0;
            end
        endcase
        if (!rd_en) begin
            next_prdata = 32'h00000000;
        end
        if (psel_i && !penable_i) begin
            next_pslverr = 1'b0;
        end
        // Latency registers are writable in name only: writes are ignored so the maximum stays honest.
        if (psel_i && penable_i && !hit) begin
            next_pslverr = 1'b1;
        end
    end

    // Read data is captured at the end of the setup cycle, so it stands for the whole access cycle.
    // The snapshot is one cycle older than the access; counts only grow between clears and overflow resets.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            control  <= `DPM_RESET_WORD;
            prdata_o <= 32'h00000000;
        end else begin
            control  <= next_control;
            prdata_o <= next_prdata;
        end
    end

    // The error answer is a handshake output and comes straight from the decode.
    assign pslverr_o = next_pslverr;

    dpm_monitor u_mon0 (
        .clk_i         (clk_i),
        .reset_i       (reset_i),
        .enable_i      (control[`DPM_BIT_EN0]),
        .freeze_mode_i (control[`DPM_BIT_OF0]),
        .clear_i       (clear[0]),
        .data_cycle_i  (m0_data),
        .stall_cycle_i (m0_stall),
        .request_i     (m0_req),
        .start_i       (m0_start),
        .data_count_o  (m0_data_count),
        .stall_count_o (m0_stall_count),
        .max_wait_o    (m0_wait)
    );

    dpm_monitor u_mon1 (
        .clk_i         (clk_i),
        .reset_i       (reset_i),
        .enable_i      (control[`DPM_BIT_EN1]),
        .freeze_mode_i (control[`DPM_BIT_OF1]),
        .clear_i       (clear[1]),
        .data_cycle_i  (m1_data),
        .stall_cycle_i (m1_stall),
        .request_i     (m1_req),
        .start_i       (m1_start),
        .data_count_o  (m1_data_count),
        .stall_count_o (m1_stall_count),
        .max_wait_o    (m1_wait)
    );
endmodule
`default_nettype wire
